// File: pkg/sbh_defines.vh
// Constants for the system bus handshake and boot-mode loader block.
`ifndef SBH_DEFINES_VH
`define SBH_DEFINES_VH

// APB register byte offsets.
`define SBH_REG_CTRL      8'h00
`define SBH_REG_ADDR      8'h04
`define SBH_REG_WDATA_LO  8'h08
`define SBH_REG_WDATA_HI  8'h0C
`define SBH_REG_CMD       8'h10
`define SBH_REG_STATUS    8'h14
`define SBH_REG_RDATA_LO  8'h18
`define SBH_REG_RDATA_HI  8'h1C
`define SBH_REG_MODE      8'h20

// Control and status bit positions.
`define SBH_CTRL_GO_READ   0
`define SBH_CTRL_GO_WRITE  1
`define SBH_STAT_BUSY      0
`define SBH_STAT_MODE_DONE 1
`define SBH_STAT_RD_DONE   2
`define SBH_STAT_BAD_EXT   3
`define SBH_STAT_EXT_OWN   4

// Boot mode stream.
`define SBH_MODE_DIV        256
`define SBH_MODE_HALF       8'h7F
`define SBH_MODE_BITS       256
`define SBH_MODE_LAST       8'hFF
`define SBH_MODE_KEEP       15
`define SBH_MODE_PACE_LO    1
`define SBH_MODE_PACE_HI    4
`define SBH_MODE_MULT_LO    5
`define SBH_MODE_MULT_HI    7
`define SBH_MODE_ENDIAN     8
`define SBH_MODE_WPROT_LO   9
`define SBH_MODE_WPROT_HI   10
`define SBH_MODE_TMR_OFF    11
`define SBH_MODE_NARROW     12
`define SBH_MODE_RESET      15'h0000

// Write protocol codes.
`define SBH_WPROT_LEGACY    2'h0
`define SBH_WPROT_PIPE      2'h2
`define SBH_WPROT_REISSUE   2'h3

// Command bus: bit 8 marks a data identifier, otherwise a command.
`define SBH_CMD_DATA_BIT    8
`define SBH_CMD_LAST_BIT    7
`define SBH_CMD_NULL        9'h0C0
`define SBH_CMD_RESET       9'h000

`endif

// File: hw/sbh_sync.v
// Two flip-flop synchroniser for signals arriving from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module sbh_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Data
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: hw/sbh_top.v
// System bus handshake engine with boot-time serial mode loader and APB registers.
//
// How it works
// - Ready inputs sampled before address is removed.
// - Ownership request answered by release, buses tristated.
// - Out-valid marks exactly the cycles driving valid.
// - One processor request outstanding at a time.
// - Read address, command and out-valid together.
// - Accepted read releases buses; agent returns data.
// - Re-issue: ready two cycles ago and now.
// - Pipelined: one extra write after ready drops.
// - Only read response and null accepted.
// - Mode clock is reference clock over 256.
// - After power-good, shift in 256 mode bits.
// - Mode clock keeps toggling, later bits ignored.
// - Bits 4..1 select writeback data pacing.
// - Bits 10..9 select the write protocol.
// - Bit 11 suppresses timer interrupt five.
// - Bit 12 selects 32-bit bus width.
// - Bits 7..5 give clock ratio two to eight.
// - Narrow bus splits wide data in two.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "sbh_defines.vh"
module sbh_top (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Handshake pins
  input  wire        read_accept_ready_n,
  input  wire        write_accept_ready_n,
  input  wire        bus_ownership_request_n,
  input  wire        in_valid_n,
  output reg         out_valid_n,
  output reg         release_n,
  // Address/data and command buses
  input  wire [63:0] addr_data_bus_in,
  output reg  [63:0] addr_data_bus_out,
  output reg         addr_data_bus_oe,
  input  wire [8:0]  command_bus_in,
  output reg  [8:0]  command_bus_out,
  output reg         command_bus_oe,
  // Boot mode serial interface
  input  wire        power_good,
  input  wire        mode_serial_in,
  output reg         mode_serial_clk,
  // Configuration and interrupt
  input  wire        timer_tick,
  output reg         timer_int5,
  output reg  [3:0]  clock_ratio
);
  localparam [2:0] S_IDLE = 3'h0, S_RD_ADDR = 3'h1, S_RD_WAIT = 3'h2,
                   S_WR_ADDR = 3'h3, S_WR_DATA = 3'h4, S_EXT = 3'h5;

  // Synchronised pins; ready and valid lines are active low on the pins.
  wire [4:0]  pins_s;
  wire [72:0] bus_s;
  wire        ser_s;
  sbh_sync #(.WIDTH(5), .INIT(5'h0F)) u_sync_ctl (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({power_good, read_accept_ready_n, write_accept_ready_n,
                bus_ownership_request_n, in_valid_n}),
    .q       (pins_s)
  );
  sbh_sync #(.WIDTH(73)) u_sync_bus (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({command_bus_in, addr_data_bus_in}),
    .q       (bus_s)
  );
  sbh_sync #(.WIDTH(1)) u_sync_ser (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (mode_serial_in),
    .q       (ser_s)
  );
  wire pgood_s  = pins_s[4];
  wire rd_rdy   = ~pins_s[3];
  wire wr_rdy   = ~pins_s[2];
  wire ext_req  = ~pins_s[1];
  wire in_valid = ~pins_s[0];
  wire [63:0] ad_in  = bus_s[63:0];
  wire [8:0]  cmd_in = bus_s[72:64];

  // Boot mode loader state.
  reg        pgood_d_q;
  reg  [7:0] div_q;
  reg  [7:0] bit_idx_q;
  reg        loading_q;
  reg        mode_done_q;
  reg [14:0] shadow_q;
  reg [14:0] mode_q;

  wire pgood_rise = pgood_s & ~pgood_d_q;
  wire sample_now = (div_q == `SBH_MODE_HALF);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgood_d_q       <= 1'b0;
      div_q           <= 8'h00;
      mode_serial_clk <= 1'b0;
      bit_idx_q       <= 8'h00;
      loading_q       <= 1'b0;
      mode_done_q     <= 1'b0;
      shadow_q        <= `SBH_MODE_RESET;
      mode_q          <= `SBH_MODE_RESET;
    end else begin
      pgood_d_q       <= pgood_s;
      div_q           <= pgood_rise ? 8'h00 : div_q + 8'h01;
      mode_serial_clk <= pgood_rise ? 1'b0 : div_q[7];
      if (pgood_rise) begin
        // A new power-good restarts the stream at bit 0.
        bit_idx_q   <= 8'h00;
        loading_q   <= 1'b1;
        mode_done_q <= 1'b0;
      end else if (loading_q && sample_now) begin
        // One sample per divided period, taken just before its rising edge.
        if (bit_idx_q < `SBH_MODE_KEEP)
          shadow_q[bit_idx_q[3:0]] <= ser_s;
        bit_idx_q <= bit_idx_q + 8'h01;
        if (bit_idx_q == `SBH_MODE_LAST) begin
          loading_q   <= 1'b0;
          mode_done_q <= 1'b1;
          mode_q      <= shadow_q;
        end
      end
    end
  end

  // Decoded configuration.
  wire [3:0] pace_code = mode_q[`SBH_MODE_PACE_HI:`SBH_MODE_PACE_LO];
  wire [1:0] wprot     = mode_q[`SBH_MODE_WPROT_HI:`SBH_MODE_WPROT_LO];
  wire       narrow    = mode_q[`SBH_MODE_NARROW];

  // Pacing pattern: bit i set means data in slot i, length is slots per repeat.
  reg [7:0] pace_mask;
  reg [3:0] pace_len;
  always @* begin
    pace_mask = 8'h01;
    pace_len  = 4'h1;
    case (pace_code)
      4'h1: begin pace_mask = 8'h03; pace_len = 4'h3; end
      4'h2: begin pace_mask = 8'h03; pace_len = 4'h4; end
      4'h3: begin pace_mask = 8'h05; pace_len = 4'h4; end
      4'h4: begin pace_mask = 8'h03; pace_len = 4'h5; end
      4'h5: begin pace_mask = 8'h03; pace_len = 4'h6; end
      4'h6: begin pace_mask = 8'h09; pace_len = 4'h6; end
      4'h7: begin pace_mask = 8'h03; pace_len = 4'h7; end
      4'h8: begin pace_mask = 8'h11; pace_len = 4'h8; end
      default: begin pace_mask = 8'h01; pace_len = 4'h1; end
    endcase
  end

  // Software-visible request registers.
  reg [31:0] addr_q;
  reg [63:0] wdata_q;
  reg  [8:0] cmd_q;
  reg [63:0] rdata_q;
  reg        rd_done_q;
  reg        bad_ext_q;

  // Bus engine state.
  reg  [2:0] state_q;
  reg        word_q;
  reg  [2:0] slot_q;
  reg  [1:0] wr_hist_q;
  reg        pipe_credit_q;
  reg  [1:0] req_q;  // Bit 0 read pending, bit 1 write pending.

  wire apb_wr   = psel & penable & pready & pwrite;
  wire ctrl_wr  = apb_wr & (paddr == `SBH_REG_CTRL);
  wire go_read  = ctrl_wr & pwdata[`SBH_CTRL_GO_READ];
  wire go_write = ctrl_wr & pwdata[`SBH_CTRL_GO_WRITE];
  // A request still waiting for ready counts as busy, so a second go is refused.
  wire busy     = (req_q != 2'h0) | ((state_q != S_IDLE) & (state_q != S_EXT));
  wire pend_ok  = mode_done_q & ~busy;

  // Write issue test per protocol.
  wire wr_issue = (wprot == `SBH_WPROT_PIPE) ? (wr_rdy | pipe_credit_q) : wr_rdy;
  wire reissue_ok = wr_hist_q[1] & wr_rdy;
  wire last_word  = ~narrow | word_q;
  wire data_slot  = pace_mask[slot_q];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q           <= S_IDLE;
      req_q             <= 2'h0;
      word_q            <= 1'b0;
      slot_q            <= 3'h0;
      wr_hist_q         <= 2'h0;
      pipe_credit_q     <= 1'b0;
      out_valid_n       <= 1'b1;
      release_n         <= 1'b1;
      addr_data_bus_out <= 64'h0000000000000000;
      addr_data_bus_oe  <= 1'b0;
      command_bus_out   <= `SBH_CMD_RESET;
      command_bus_oe    <= 1'b0;
      rdata_q           <= 64'h0000000000000000;
      rd_done_q         <= 1'b0;
      bad_ext_q         <= 1'b0;
    end else begin
      wr_hist_q <= {wr_hist_q[0], wr_rdy};
      if (wr_rdy)
        pipe_credit_q <= 1'b1;
      // Software requests are taken only when the engine is free.
      if (go_read && pend_ok)
        req_q <= 2'h1;
      else if (go_write && pend_ok)
        req_q <= 2'h2;
      // Sticky flags: a hardware set wins over a software clear.
      if (apb_wr && paddr == `SBH_REG_STATUS) begin
        if (pwdata[`SBH_STAT_RD_DONE])
          rd_done_q <= 1'b0;
        if (pwdata[`SBH_STAT_BAD_EXT])
          bad_ext_q <= 1'b0;
      end
      out_valid_n <= 1'b1;
      case (state_q)
        S_IDLE: begin
          addr_data_bus_oe <= 1'b1;
          command_bus_oe   <= 1'b1;
          release_n        <= 1'b1;
          if (ext_req) begin
            state_q          <= S_EXT;
            release_n        <= 1'b0;
            addr_data_bus_oe <= 1'b0;
            command_bus_oe   <= 1'b0;
          end else if (req_q[0] && rd_rdy) begin
            addr_data_bus_out <= {32'h00000000, addr_q};
            command_bus_out   <= cmd_q;
            out_valid_n       <= 1'b0;
            state_q           <= S_RD_ADDR;
          end else if (req_q[1] && wr_issue) begin
            if (!wr_rdy)
              pipe_credit_q <= 1'b0;
            addr_data_bus_out <= {32'h00000000, addr_q};
            command_bus_out   <= cmd_q;
            out_valid_n       <= 1'b0;
            state_q           <= S_WR_ADDR;
          end
        end
        S_RD_ADDR: begin
          // The address stays until read-ready has been seen again.
          if (rd_rdy) begin
            addr_data_bus_oe <= 1'b0;
            command_bus_oe   <= 1'b0;
            release_n        <= 1'b0;
            word_q           <= 1'b0;
            req_q            <= 2'h0;
            state_q          <= S_RD_WAIT;
          end else begin
            out_valid_n <= 1'b0;
          end
        end
        S_RD_WAIT: begin
          // Only the agent's valid cycles on the released buses are looked at.
          if (in_valid) begin
            if (cmd_in[`SBH_CMD_DATA_BIT]) begin
              if (narrow && word_q)
                rdata_q[63:32] <= ad_in[31:0];
              else
                rdata_q <= narrow ? {rdata_q[63:32], ad_in[31:0]} : ad_in;
              word_q <= ~word_q;
              if (last_word) begin
                rd_done_q <= 1'b1;
                release_n <= 1'b1;
                state_q   <= S_IDLE;
              end
            end else if (cmd_in != `SBH_CMD_NULL) begin
              bad_ext_q <= 1'b1;
            end
          end
        end
        S_WR_ADDR: begin
          if (wprot == `SBH_WPROT_REISSUE && !reissue_ok) begin
            out_valid_n <= 1'b0;
          end else if (wprot == `SBH_WPROT_LEGACY && !wr_rdy) begin
            out_valid_n <= 1'b0;
          end else begin
            word_q  <= 1'b0;
            slot_q  <= 3'h0;
            state_q <= S_WR_DATA;
          end
        end
        S_WR_DATA: begin
          // Idle slots of the pacing pattern leave out-valid high.
          slot_q <= (slot_q == pace_len - 4'h1) ? 3'h0 : slot_q + 3'h1;
          if (data_slot) begin
            addr_data_bus_out <= (narrow && word_q) ? {32'h00000000, wdata_q[63:32]} :
                                 narrow ? {32'h00000000, wdata_q[31:0]} : wdata_q;
            command_bus_out   <= last_word ? (9'h100 | 9'h080) : 9'h100;
            out_valid_n       <= 1'b0;
            word_q            <= ~word_q;
            if (last_word) begin
              req_q   <= 2'h0;
              state_q <= S_IDLE;
            end
          end
        end
        S_EXT: begin
          if (!ext_req) begin
            release_n <= 1'b1;
            state_q   <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Configuration outputs.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_int5  <= 1'b0;
      clock_ratio <= 4'h2;
    end else begin
      timer_int5  <= timer_tick & ~mode_q[`SBH_MODE_TMR_OFF];
      clock_ratio <= (mode_q[7:5] == 3'h7) ? 4'h2 : {1'b0, mode_q[7:5]} + 4'h2;
    end
  end

  // APB: answer in the second access cycle, reads from registered data.
  reg [31:0] rd_mux;
  reg        hit;
  always @* begin
    rd_mux = 32'h00000000;
    hit    = 1'b1;
    case (paddr)
      `SBH_REG_CTRL:     rd_mux = {31'h00000000, busy};
      `SBH_REG_ADDR:     rd_mux = addr_q;
      `SBH_REG_WDATA_LO: rd_mux = wdata_q[31:0];
      `SBH_REG_WDATA_HI: rd_mux = wdata_q[63:32];
      `SBH_REG_CMD:      rd_mux = {23'h000000, cmd_q};
      `SBH_REG_STATUS:   rd_mux = {27'h0000000, state_q == S_EXT, bad_ext_q, rd_done_q, mode_done_q, busy};
      `SBH_REG_RDATA_LO: rd_mux = rdata_q[31:0];
      `SBH_REG_RDATA_HI: rd_mux = rdata_q[63:32];
      `SBH_REG_MODE:     rd_mux = {17'h00000, mode_q};
      default:           hit    = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      addr_q  <= 32'h00000000;
      wdata_q <= 64'h0000000000000000;
      cmd_q   <= `SBH_CMD_RESET;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel && penable && !pready)
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      if (apb_wr) begin
        case (paddr)
          `SBH_REG_ADDR:     addr_q         <= pwdata;
          `SBH_REG_WDATA_LO: wdata_q[31:0]  <= pwdata;
          `SBH_REG_WDATA_HI: wdata_q[63:32] <= pwdata;
          `SBH_REG_CMD:      cmd_q          <= pwdata[8:0];
          default:           cmd_q          <= cmd_q;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: test/sbh_props.sv
// Port-level assertions for the handshake and mode loader block.
`timescale 1ns/10ps
`default_nettype none
module sbh_props (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Handshake and bus enables
  input wire logic       out_valid_n,
  input wire logic       release_n,
  input wire logic       addr_data_bus_oe,
  input wire logic       command_bus_oe,
  // Mode loader and configuration
  input wire logic       power_good,
  input wire logic       mode_serial_clk,
  input wire logic       timer_tick,
  input wire logic       timer_int5,
  input wire logic [3:0] clock_ratio
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] hcnt_q;
  logic [3:0] pg_q;
  logic       mclk_q;
  logic       seen_q;
  // A power-good edge restarts the divider, so the half period after it is not judged.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_q <= 8'h00;
      pg_q   <= 4'h0;
      mclk_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      pg_q   <= {pg_q[2:0], power_good};
      mclk_q <= mode_serial_clk;
      hcnt_q <= (mode_serial_clk != mclk_q) ? 8'h00 : hcnt_q + 8'h01;
      if (pg_q != 4'h0 && pg_q != 4'hF) begin
        seen_q <= 1'b0;
      end else if (mode_serial_clk != mclk_q) begin
        seen_q <= 1'b1;
      end
    end
  end
  a_valid_drives: assert property (!out_valid_n |-> addr_data_bus_oe && command_bus_oe)
    else $error("out_valid_n low while buses undriven");
  a_buses_paired: assert property (addr_data_bus_oe == command_bus_oe)
    else $error("bus enables differ");
  a_release_tristate: assert property (!release_n |-> !addr_data_bus_oe)
    else $error("bus driven while released");
  a_release_quiet: assert property (!release_n |-> out_valid_n)
    else $error("request issued while released");
  a_mclk_period: assert property (seen_q && mode_serial_clk != mclk_q |-> hcnt_q == 8'h7F)
    else $error("mode clock half period not 128");
  a_mclk_runs: assert property (hcnt_q < 8'hC0)
    else $error("mode clock stopped");
  a_timer_cause: assert property (timer_int5 |-> $past(timer_tick))
    else $error("timer interrupt without tick");
  a_ratio_range: assert property (clock_ratio >= 4'h2 && clock_ratio <= 4'h8)
    else $error("clock ratio out of range");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  c_release: cover property ($fell(release_n));
  c_error: cover property (pslverr);
  c_mclk: cover property (seen_q && $rose(mode_serial_clk));
endmodule
bind sbh_top sbh_props u_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .out_valid_n, .release_n,
  .addr_data_bus_oe, .command_bus_oe, .power_good, .mode_serial_clk, .timer_tick, .timer_int5, .clock_ratio);
`default_nettype wire

// File: test/sbh_agent.sv
// Behavioural far-side agent: boot mode source and memory controller.
`timescale 1ns/10ps
`default_nettype none
module sbh_agent #(
  parameter logic [14:0] MODE     = 15'h0000,
  parameter logic [63:0] RDATA    = 64'h0,
  parameter logic [8:0]  READ_CMD = 9'h040
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Stall control
  input  wire logic        slow,
  // Boot mode stream
  input  wire logic        power_good,
  input  wire logic        mode_serial_clk,
  output var  logic        mode_serial_in,
  // Handshake and buses
  input  wire logic        out_valid_n,
  input  wire logic        release_n,
  input  wire logic [63:0] addr_data_bus_out,
  input  wire logic [8:0]  command_bus_out,
  output wire logic        read_accept_ready_n,
  output wire logic        write_accept_ready_n,
  output var  logic        in_valid_n,
  output var  logic [63:0] addr_data_bus_in,
  output var  logic [8:0]  command_bus_in,
  output var  logic [63:0] wr_data
);
  int   bitn = 300;
  logic rd_q;
  assign read_accept_ready_n  = slow;
  assign write_accept_ready_n = slow;
  // The bench raises power-good while the serial clock is low, which tells the two events apart.
  always @(posedge power_good or posedge mode_serial_clk)
    if (mode_serial_clk)
      bitn <= bitn + 1;
    else
      bitn <= 0;
  // Past the stream the input toggles, so a loader that keeps reading would be caught.
  always @* mode_serial_in = (bitn < 15) ? MODE[bitn] : ((bitn > 255) ? bitn[0] : 1'b0);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q    <= 1'b0;
      wr_data <= 64'h0;
    end else begin
      if (!out_valid_n && command_bus_out == READ_CMD) rd_q <= 1'b1;
      // Read addresses land here too, so the bench can check the address cycle.
      if (!out_valid_n && (command_bus_out[8] || command_bus_out == READ_CMD)) wr_data <= addr_data_bus_out;
      if (!in_valid_n) rd_q <= 1'b0;
    end
  end
  initial begin
    in_valid_n       = 1'b1;
    addr_data_bus_in = ~RDATA;
    command_bus_in   = ~9'h180;
    forever begin
      @(posedge pclk);
      if (rd_q && !release_n && in_valid_n) begin
        repeat (3) @(posedge pclk);
        in_valid_n       <= 1'b0;
        addr_data_bus_in <= RDATA;
        command_bus_in   <= 9'h180;
        @(posedge pclk);
        in_valid_n       <= 1'b1;
        addr_data_bus_in <= ~RDATA;
        command_bus_in   <= ~9'h180;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/sbh_top_bench.sv
// Self-checking bench for the handshake and mode loader block.
`timescale 1ns/10ps
`default_nettype none
`include "sbh_defines.vh"
module sbh_top_bench;
  localparam logic [14:0] MODE  = 15'h0866;
  localparam logic [63:0] RDATA = 64'h0123_4567_89AB_CDEF;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, power_good, timer_tick, timer_int5;
  logic        read_accept_ready_n, write_accept_ready_n, bus_ownership_request_n, in_valid_n, out_valid_n;
  logic        release_n, addr_data_bus_oe, command_bus_oe, mode_serial_in, mode_serial_clk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [63:0] addr_data_bus_in, addr_data_bus_out, wr_data;
  logic [8:0]  command_bus_in, command_bus_out;
  logic [3:0]  clock_ratio;
  logic        err;
  int          n_mismatch, n_tests, n;
  sbh_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .read_accept_ready_n, .write_accept_ready_n, .bus_ownership_request_n, .in_valid_n, .out_valid_n,
    .release_n, .addr_data_bus_in, .addr_data_bus_out, .addr_data_bus_oe, .command_bus_in, .command_bus_out,
    .command_bus_oe, .power_good, .mode_serial_in, .mode_serial_clk, .timer_tick, .timer_int5, .clock_ratio);
  sbh_agent #(.MODE(MODE), .RDATA(RDATA)) u_agent (.pclk, .presetn, .slow, .power_good, .mode_serial_clk,
    .mode_serial_in, .out_valid_n, .release_n, .addr_data_bus_out, .command_bus_out, .read_accept_ready_n,
    .write_accept_ready_n, .in_valid_n, .addr_data_bus_in, .command_bus_in, .wr_data);
  always #5 pclk = ~pclk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Setup, then access held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(what, exp, r);
  endtask
  task automatic poll(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0, r);
      k++;
    end while ((r & m) !== v && k < 20000);
    chk(what, v, r & m);
    if ((r & m) !== v) stop_test();
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, slow, power_good, timer_tick} = 8'h00;
    bus_ownership_request_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (4) @(posedge pclk);
    chk("release idle", 32'h1, {31'h0, release_n});
    chk("valid idle", 32'h1, {31'h0, out_valid_n});
    chk("ratio reset", 32'h2, {28'h0, clock_ratio});
    presetn <= 1'b1;
    rc("status reset", `SBH_REG_STATUS, 32'h0);
    rc("unmapped", 8'h24, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    @(negedge pclk);
    chk("timer on", 32'h1, {31'h0, timer_int5});
    $display("test reset ended");
    // Start the stream just after a serial clock fall so no rise lands before the divider restarts.
    repeat (260) if (mode_serial_clk !== 1'b1) @(posedge pclk);
    repeat (260) if (mode_serial_clk !== 1'b0) @(posedge pclk);
    chk("mode clock low", 32'h0, {31'h0, mode_serial_clk});
    power_good <= 1'b1;
    poll("mode done", `SBH_REG_STATUS, 32'h2, 32'h2);
    rc("mode bits", `SBH_REG_MODE, {17'h0, MODE});
    chk("ratio", 32'h5, {28'h0, clock_ratio});
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    repeat (2) @(negedge pclk);
    chk("timer off", 32'h0, {31'h0, timer_int5});
    $display("test mode ended");
    wr(`SBH_REG_ADDR, 32'h1000_0040);
    wr(`SBH_REG_CMD, 32'h0000_0040);
    wr(`SBH_REG_CTRL, 32'h1);
    poll("read done", `SBH_REG_STATUS, 32'h4, 32'h4);
    chk("read addr", 32'h1000_0040, wr_data[31:0]);
    rc("rdata lo", `SBH_REG_RDATA_LO, RDATA[31:0]);
    rc("rdata hi", `SBH_REG_RDATA_HI, RDATA[63:32]);
    chk("release back", 32'h1, {31'h0, release_n});
    wr(`SBH_REG_STATUS, 32'h4);
    rc("status clr", `SBH_REG_STATUS, 32'h2);
    $display("test read ended");
    slow <= 1'b1;
    wr(`SBH_REG_WDATA_LO, 32'h5555_AAAA);
    wr(`SBH_REG_WDATA_HI, 32'h3C3C_C3C3);
    wr(`SBH_REG_CMD, 32'h0000_00A0);
    wr(`SBH_REG_CTRL, 32'h2);
    repeat (30) @(posedge pclk);
    rc("busy stalled", `SBH_REG_STATUS, 32'h3);
    wr(`SBH_REG_CTRL, 32'h1);
    chk("no data stalled", 32'h1000_0040, wr_data[31:0]);
    slow <= 1'b0;
    poll("write done", `SBH_REG_STATUS, 32'h1, 32'h0);
    chk("write lo", 32'h5555_AAAA, wr_data[31:0]);
    chk("write hi", 32'h3C3C_C3C3, wr_data[63:32]);
    rc("no second req", `SBH_REG_STATUS, 32'h2);
    $display("test write ended");
    bus_ownership_request_n <= 1'b0;
    for (n = 0; n < 50 && release_n !== 1'b0; n++) @(posedge pclk);
    chk("release on req", 32'h0, {31'h0, release_n});
    rc("owned", `SBH_REG_STATUS, 32'h12);
    bus_ownership_request_n <= 1'b1;
    for (n = 0; n < 50 && release_n !== 1'b1; n++) @(posedge pclk);
    chk("release dropped", 32'h1, {31'h0, release_n});
    rc("mode kept", `SBH_REG_MODE, {17'h0, MODE});
    $display("test ownership ended");
    stop_test();
  end
endmodule
`default_nettype wire
